// file: hdl/combo_bus_pkg.sv
package combo_bus_pkg;

	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	// bus phase lengths in ns, converted to 100 MHz cycles (least times round up)
	localparam int CLK_NS      = 10;
	localparam int SETUP_NS    = 20;
	localparam int STROBE_NS   = 90;
	localparam int HOLD_NS     = 20;
	localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
	localparam logic [3:0] HOLD_CNT   = 4'(HOLD_CYC);

	// partition operation states, used for concurrency checks
	typedef enum logic [3:0] {
		OP_READ_ARRAY = 4'h0,
		OP_READ_ID    = 4'h1,
		OP_READ_STAT  = 4'h2,
		OP_READ_QUERY = 4'h3,
		OP_WORD_PROG  = 4'h4,
		OP_PAGE_PROG  = 4'h5,
		OP_BLK_ERASE  = 4'h6,
		OP_CHIP_ERASE = 4'h7,
		OP_PROG_SUSP  = 4'h8,
		OP_ERASE_SUSP = 4'h9
	} part_op_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETUP  = 3'h1,
		ST_STROBE = 3'h2,
		ST_HOLD   = 3'h3,
		ST_DONE   = 3'h4
	} bus_state_t;

	// one host request
	typedef struct packed {
		logic              is_ram;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        lane_n;
		logic              part;
		part_op_t          op;
	} req_t;

	// all pins driven toward the memory
	typedef struct packed {
		logic              flash_chip_select_n;
		logic              flash_output_enable_n;
		logic              flash_write_enable_n;
		logic              flash_reset_n;
		logic              flash_write_protect_n;
		logic              ram_chip_select_n;
		logic              ram_sleep_n;
		logic              ram_output_enable_n;
		logic              ram_write_enable_n;
		logic              ram_low_lane_enable_n;
		logic              ram_high_lane_enable_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic [1:0]        dq_oe;
	} pins_t;

endpackage : combo_bus_pkg

// file: hdl/combo_bus_host.sv
`timescale 1ns/1ps
`default_nettype none

module combo_bus_host
	import combo_bus_pkg::*;
(
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// request side
	input  wire logic                      req_valid_i,
	input  wire combo_bus_pkg::req_t       req_i,
	input  wire logic                      power_down_i,
	input  wire logic                      write_protect_i,
	input  wire logic                      ram_sleep_i,
	output logic                           req_ready_o,
	output logic                           done_o,
	output logic                           refused_o,
	output logic [combo_bus_pkg::DATA_W-1:0] rdata_o,
	output logic                           flash_busy_o,
	// memory pins
	output combo_bus_pkg::pins_t           pins_o,
	input  wire logic [combo_bus_pkg::DATA_W-1:0] dq_i,
	input  wire logic                      flash_ready_busy_n_i
);
	import combo_bus_pkg::*;

	typedef struct packed {
		bus_state_t        st;
		logic [3:0]        cnt;
		req_t              rq;
		part_op_t [1:0]    part_op;
		logic              done;
		logic              refused;
		logic [DATA_W-1:0] rdata;
		logic              busy;
		logic              ready;
		pins_t             pins;
	} state_t;

	state_t cur_ff;
	state_t nxt_cur;

	// partitions may run op a beside op b
	function automatic logic pair_ok(input part_op_t a, input part_op_t b);
		logic rd_b;
		rd_b = (b == OP_READ_ARRAY) || (b == OP_READ_ID) || (b == OP_READ_STAT)
			|| (b == OP_READ_QUERY);
		unique case (a)
			OP_READ_ARRAY, OP_READ_ID, OP_READ_QUERY:
				pair_ok = (b != OP_CHIP_ERASE);
			OP_READ_STAT:
				pair_ok = 1'b1;
			OP_WORD_PROG, OP_PAGE_PROG, OP_PROG_SUSP:
				pair_ok = rd_b || (b == OP_ERASE_SUSP);
			OP_BLK_ERASE:
				pair_ok = rd_b;
			OP_CHIP_ERASE:
				pair_ok = (b == OP_READ_STAT);
			OP_ERASE_SUSP:
				pair_ok = rd_b || (b == OP_WORD_PROG) || (b == OP_PAGE_PROG)
					|| (b == OP_PROG_SUSP);
			default:
				pair_ok = 1'b0;
		endcase
	endfunction

	function automatic logic is_active(input part_op_t a);
		is_active = (a == OP_WORD_PROG) || (a == OP_PAGE_PROG) || (a == OP_BLK_ERASE)
			|| (a == OP_CHIP_ERASE);
	endfunction

	logic     other_p;
	part_op_t other_op;
	logic     allowed;

	always_comb
	begin
		other_p  = ~req_i.part;
		other_op = cur_ff.part_op[other_p];
		// the pair table is symmetric, yet both directions are checked
		allowed  = pair_ok(req_i.op, other_op) && pair_ok(other_op, req_i.op)
			&& !(is_active(req_i.op) && is_active(other_op));
		nxt_cur         = cur_ff;
		nxt_cur.done    = 1'b0;
		nxt_cur.refused = 1'b0;
		nxt_cur.busy    = ~flash_ready_busy_n_i;
		// power-down waits for a running flash cycle so reset never cuts an access
		if (cur_ff.st == ST_IDLE || cur_ff.rq.is_ram)
			nxt_cur.pins.flash_reset_n     = ~power_down_i;
		nxt_cur.pins.flash_write_protect_n = ~write_protect_i;
		nxt_cur.pins.ram_sleep_n           = ~ram_sleep_i;
		unique case (cur_ff.st)
			ST_IDLE:
			begin
				if (req_valid_i)
				begin
					if (!req_i.is_ram && (power_down_i || !allowed))
						nxt_cur.refused = 1'b1;
					else if (req_i.is_ram && ram_sleep_i)
						nxt_cur.refused = 1'b1;
					else
					begin
						nxt_cur.rq   = req_i;
						nxt_cur.st   = ST_SETUP;
						nxt_cur.cnt  = SETUP_CNT;
						// command address is the block address itself
						nxt_cur.pins.addr = req_i.addr;
						if (req_i.is_ram)
						begin
							nxt_cur.pins.ram_chip_select_n      = 1'b0;
							nxt_cur.pins.ram_low_lane_enable_n  = req_i.lane_n[0];
							nxt_cur.pins.ram_high_lane_enable_n = req_i.lane_n[1];
						end
						else
							nxt_cur.pins.flash_chip_select_n = 1'b0;
						if (req_i.write)
						begin
							nxt_cur.pins.dq_out = req_i.wdata;
							nxt_cur.pins.dq_oe  = req_i.is_ram ? ~req_i.lane_n : 2'h3;
						end
					end
				end
			end
			ST_SETUP:
			begin
				nxt_cur.cnt = cur_ff.cnt - 4'h1;
				if (cur_ff.cnt == 4'h1)
				begin
					nxt_cur.st  = ST_STROBE;
					nxt_cur.cnt = STROBE_CNT;
					// exactly one strobe per cycle type keeps oe and we apart
					if (cur_ff.rq.is_ram)
					begin
						nxt_cur.pins.ram_write_enable_n  = ~cur_ff.rq.write;
						nxt_cur.pins.ram_output_enable_n = cur_ff.rq.write;
					end
					else
					begin
						nxt_cur.pins.flash_write_enable_n  = ~cur_ff.rq.write;
						nxt_cur.pins.flash_output_enable_n = cur_ff.rq.write;
					end
				end
			end
			ST_STROBE:
			begin
				nxt_cur.cnt = cur_ff.cnt - 4'h1;
				if (cur_ff.cnt == 4'h1)
				begin
					nxt_cur.st  = ST_HOLD;
					nxt_cur.cnt = HOLD_CNT;
					if (!cur_ff.rq.write)
						nxt_cur.rdata = dq_i;
					nxt_cur.pins.flash_write_enable_n  = 1'b1;
					nxt_cur.pins.flash_output_enable_n = 1'b1;
					nxt_cur.pins.ram_write_enable_n    = 1'b1;
					nxt_cur.pins.ram_output_enable_n   = 1'b1;
				end
			end
			ST_HOLD:
			begin
				nxt_cur.cnt = cur_ff.cnt - 4'h1;
				if (cur_ff.cnt == 4'h1)
				begin
					nxt_cur.st   = ST_DONE;
					nxt_cur.pins.dq_oe                  = 2'h0;
					nxt_cur.pins.flash_chip_select_n    = 1'b1;
					nxt_cur.pins.ram_chip_select_n      = 1'b1;
					nxt_cur.pins.ram_low_lane_enable_n  = 1'b1;
					nxt_cur.pins.ram_high_lane_enable_n = 1'b1;
				end
			end
			ST_DONE:
			begin
				nxt_cur.st   = ST_IDLE;
				nxt_cur.done = 1'b1;
				if (!cur_ff.rq.is_ram)
					nxt_cur.part_op[cur_ff.rq.part] = cur_ff.rq.op;
			end
			default:
				nxt_cur.st = ST_IDLE;
		endcase
		nxt_cur.ready = (nxt_cur.st == ST_IDLE);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur_ff      <= '0;
			cur_ff.ready <= 1'b1;
			cur_ff.pins <= '{flash_chip_select_n: 1'b1, flash_output_enable_n: 1'b1,
				flash_write_enable_n: 1'b1, flash_reset_n: 1'b0,
				flash_write_protect_n: 1'b0, ram_chip_select_n: 1'b1,
				ram_sleep_n: 1'b1, ram_output_enable_n: 1'b1, ram_write_enable_n: 1'b1,
				ram_low_lane_enable_n: 1'b1, ram_high_lane_enable_n: 1'b1,
				addr: '0, dq_out: '0, dq_oe: 2'h0};
		end
		else
			cur_ff <= nxt_cur;
	end

	assign req_ready_o  = cur_ff.ready;
	assign done_o       = cur_ff.done;
	assign refused_o    = cur_ff.refused;
	assign rdata_o      = cur_ff.rdata;
	assign flash_busy_o = cur_ff.busy;
	assign pins_o       = cur_ff.pins;

	property p_oe_we_apart;
		@(posedge clk_i) disable iff (rst_i)
		!(!pins_o.flash_output_enable_n && !pins_o.flash_write_enable_n);
	endproperty
	a_oe_we_apart: assert property (p_oe_we_apart) else $error("flash oe and we low together");

	property p_reset_idle;
		@(posedge clk_i) disable iff (rst_i)
		!pins_o.flash_reset_n |-> pins_o.flash_chip_select_n;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("flash access in power-down");

	property p_lane_float;
		@(posedge clk_i) disable iff (rst_i)
		!pins_o.ram_chip_select_n |-> (!pins_o.ram_low_lane_enable_n || !pins_o.dq_oe[0])
			&& (!pins_o.ram_high_lane_enable_n || !pins_o.dq_oe[1]);
	endproperty
	a_lane_float: assert property (p_lane_float) else $error("disabled ram lane driven");

	sequence s_write_strobe;
		$fell(pins_o.flash_write_enable_n);
	endsequence
	sequence s_data_held;
		(pins_o.dq_oe == 2'h3) [*8];
	endsequence
	property p_write_data;
		@(posedge clk_i) disable iff (rst_i)
		s_write_strobe |-> s_data_held;
	endproperty
	a_write_data: assert property (p_write_data) else $error("flash write without data");

	property p_flash_read;
		@(posedge clk_i) disable iff (rst_i)
		$fell(pins_o.flash_output_enable_n) |-> !pins_o.flash_chip_select_n
			&& pins_o.flash_write_enable_n && pins_o.flash_reset_n && pins_o.dq_oe == 2'h0;
	endproperty
	a_flash_read: assert property (p_flash_read) else $error("bad flash read cycle");

	property p_ram_strobe;
		@(posedge clk_i) disable iff (rst_i)
		$fell(pins_o.ram_output_enable_n) || $fell(pins_o.ram_write_enable_n)
			|-> !pins_o.ram_chip_select_n && pins_o.ram_sleep_n;
	endproperty
	a_ram_strobe: assert property (p_ram_strobe) else $error("ram strobe while unselected");

	property p_one_active;
		@(posedge clk_i) disable iff (rst_i)
		!(is_active(cur_ff.part_op[0]) && is_active(cur_ff.part_op[1]));
	endproperty
	a_one_active: assert property (p_one_active) else $error("two partitions busy");

	property p_strobe_len;
		@(posedge clk_i) disable iff (rst_i)
		cur_ff.st == ST_SETUP && cur_ff.cnt == 4'h1 |-> ##9 cur_ff.st == ST_STROBE ##1
			cur_ff.st == ST_HOLD;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");

endmodule : combo_bus_host

`default_nettype wire

// file: bench/flash_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_ram_model
	import combo_bus_pkg::*;
(
	// clock for the idle pattern only
	input  wire logic                 clk_i,
	// memory pins
	input  wire combo_bus_pkg::pins_t pins_i,
	input  wire logic                 busy_i,
	output logic [15:0]               dq_o,
	output logic                      rb_n_o
);
	logic [15:0] fmem [16] = '{default: 16'h0000};
	logic [15:0] rmem [16] = '{default: 16'h0000};
	logic [15:0] drv;
	logic [1:0]  en;
	logic        tick = 1'b0;
	logic        f_rd;
	logic        r_on;

	always @(posedge clk_i) tick <= ~tick;
	assign f_rd = !pins_i.flash_chip_select_n && !pins_i.flash_output_enable_n
		&& pins_i.flash_write_enable_n && pins_i.flash_reset_n;
	assign r_on = !pins_i.ram_chip_select_n && pins_i.ram_sleep_n;
	// open drain: released line is pulled up
	assign rb_n_o = !busy_i;

	// the top word sits in a locked block, so program attempts there are dropped
	always @(posedge pins_i.flash_write_enable_n)
		if (!pins_i.flash_chip_select_n && pins_i.flash_reset_n
			&& pins_i.addr[3:0] != 4'hF)
			fmem[pins_i.addr[3:0]] = pins_i.dq_out;

	always @(posedge pins_i.ram_write_enable_n or negedge pins_i.ram_sleep_n)
		if (!pins_i.ram_sleep_n)
			rmem = '{default: 16'h0000};
		else if (r_on)
		begin
			if (!pins_i.ram_low_lane_enable_n)
				rmem[pins_i.addr[3:0]][7:0] = pins_i.dq_out[7:0];
			if (!pins_i.ram_high_lane_enable_n)
				rmem[pins_i.addr[3:0]][15:8] = pins_i.dq_out[15:8];
		end

	// an undriven lane toggles so a stale value can never pass for data
	always_comb
	begin
		drv = f_rd ? fmem[pins_i.addr[3:0]] : rmem[pins_i.addr[3:0]];
		en  = {2{f_rd}};
		if (r_on && !pins_i.ram_output_enable_n && pins_i.ram_write_enable_n)
			en = ~{pins_i.ram_high_lane_enable_n, pins_i.ram_low_lane_enable_n};
		for (int l = 0; l < 2; l++)
			dq_o[l*8+:8] = pins_i.dq_oe[l] ? pins_i.dq_out[l*8+:8]
				: en[l] ? drv[l*8+:8] : {8{tick}} ^ 8'hA5;
	end
endmodule // flash_ram_model
`default_nettype wire

// file: bench/combo_flash_ram_bus_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module combo_flash_ram_bus_control_bench;
	import combo_bus_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        req_valid_i = 1'b0;
	req_t        req_i = '0;
	logic        power_down_i = 1'b0;
	logic        write_protect_i = 1'b0;
	logic        ram_sleep_i = 1'b0;
	logic        busy = 1'b0;
	logic        req_ready_o, done_o, refused_o, flash_busy_o, rb_n;
	logic [15:0] rdata_o, dq;
	pins_t       pins_o;
	int          n_errors = 0;
	int          n_tests = 0;
	logic [15:0] shadow_r [16] = '{default: 16'h0000};
	logic [15:0] shadow_f [16] = '{default: 16'h0000};
	logic [9:0]  allow [10] = '{10'h37F, 10'h37F, 10'h3FF, 10'h37F, 10'h20F,
		10'h20F, 10'h00F, 10'h004, 10'h20F, 10'h13F};

	always #5 clk_i = ~clk_i;

	combo_bus_host combo_bus_host_i (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .power_down_i(power_down_i), .write_protect_i(write_protect_i),
		.ram_sleep_i(ram_sleep_i), .req_ready_o(req_ready_o), .done_o(done_o),
		.refused_o(refused_o), .rdata_o(rdata_o), .flash_busy_o(flash_busy_o),
		.pins_o(pins_o), .dq_i(dq), .flash_ready_busy_n_i(rb_n));
	flash_ram_model flash_ram_model_i (.clk_i(clk_i), .pins_i(pins_o), .busy_i(busy),
		.dq_o(dq), .rb_n_o(rb_n));

	task automatic results;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
		input logic [15:0] m);
		n_tests++;
		if ((got & m) !== (exp & m))
		begin
			n_errors++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic ram, input logic wr, input logic [3:0] a,
		input logic [15:0] d, input logic [1:0] ln, input logic p, input part_op_t op,
		output logic refd);
		int k;
		for (k = 0; k < 30 && req_ready_o !== 1'b1; k++) @(negedge clk_i);
		req_i = '{ram, wr, 21'(a), d, ln, p, op};
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		for (k = 0; k < 30 && done_o !== 1'b1 && refused_o !== 1'b1; k++) @(negedge clk_i);
		refd = refused_o;
		if (!refd)
			chk_word(16'(k), 16'(SETUP_CYC + STROBE_CYC + HOLD_CYC + 1), 16'hFFFF);
		if (k == 30)
		begin
			n_errors++;
			$display("[ERR] %0t transfer never finished", $time);
		end
		@(negedge clk_i);
	endtask

	// flash oe and we strobes must never overlap, whatever the request mix
	always @(negedge clk_i)
		if (!rst_i && !pins_o.flash_output_enable_n && !pins_o.flash_write_enable_n)
		begin
			n_errors++;
			$display("[ERR] %0t flash read and write strobes together", $time);
		end

	initial
	begin
		#200000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		results();
	end

	initial
	begin
		logic        r;
		logic [15:0] d;
		logic [1:0]  ln;
		logic [3:0]  a;
		void'($urandom(58));
		repeat (3) @(negedge clk_i);
		chk_bit(pins_o.flash_reset_n, 1'b0);
		chk_bit(pins_o.ram_chip_select_n, 1'b1);
		rst_i = 1'b0;
		repeat (24)
		begin
			a = 4'($urandom);
			d = 16'($urandom);
			ln = 2'($urandom);
			xfer(1'b1, 1'b1, a, d, ln, 1'b0, OP_READ_ARRAY, r);
			if (!ln[0]) shadow_r[a][7:0] = d[7:0];
			if (!ln[1]) shadow_r[a][15:8] = d[15:8];
			ln = 2'($urandom);
			xfer(1'b1, 1'b0, a, 16'h0000, ln, 1'b0, OP_READ_ARRAY, r);
			chk_word(rdata_o, shadow_r[a], {{8{!ln[1]}}, {8{!ln[0]}}});
		end
		for (int i = 0; i < 12; i++)
		begin
			// first pass aims at the locked word on purpose
			a = (i == 0) ? 4'hF : 4'($urandom);
			d = 16'($urandom);
			busy = 1'($urandom);
			write_protect_i = 1'($urandom);
			xfer(1'b0, 1'b1, a, d, 2'b00, 1'b0, OP_READ_ARRAY, r);
			if (a != 4'hF) shadow_f[a] = d;
			xfer(1'b0, 1'b0, a, 16'h0000, 2'b00, 1'b0, OP_READ_ARRAY, r);
			chk_word(rdata_o, shadow_f[a], 16'hFFFF);
			chk_bit(pins_o.flash_write_protect_n, !write_protect_i);
			chk_bit(flash_busy_o, busy);
			chk_bit(pins_o.ram_chip_select_n, 1'b1);
		end
		busy = 1'b0;
		power_down_i = 1'b1;
		xfer(1'b0, 1'b0, a, 16'h0000, 2'b00, 1'b0, OP_READ_ARRAY, r);
		chk_bit(r, 1'b1);
		chk_bit(pins_o.flash_reset_n, 1'b0);
		xfer(1'b1, 1'b0, a, 16'h0000, 2'b00, 1'b0, OP_READ_ARRAY, r);
		chk_word(rdata_o, shadow_r[a], 16'hFFFF);
		power_down_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk_bit(pins_o.flash_reset_n, 1'b1);
		// sleep loses RAM contents, so it comes after every RAM check
		ram_sleep_i = 1'b1;
		xfer(1'b1, 1'b0, a, 16'h0000, 2'b00, 1'b0, OP_READ_ARRAY, r);
		chk_bit(r, 1'b1);
		chk_bit(pins_o.ram_sleep_n, 1'b0);
		ram_sleep_i = 1'b0;
		for (int x = 0; x < 10; x++)
			for (int y = 0; y < 10; y++)
			begin
				xfer(1'b0, 1'b0, 4'h0, 16'h0000, 2'b00, 1'b1, OP_READ_STAT, r);
				xfer(1'b0, 1'b0, 4'h1, 16'h0000, 2'b00, 1'b0, part_op_t'(x), r);
				chk_bit(r, 1'b0);
				xfer(1'b0, 1'b0, 4'h2, 16'h0000, 2'b00, 1'b1, part_op_t'(y), r);
				chk_bit(r, !allow[x][y]);
			end
		results();
	end
endmodule // combo_flash_ram_bus_control_bench
`default_nettype wire
